// File: inc/iosj_pkg.sv
/*
 Constants, types and helpers for the increment, OR, shift and jump
 execution block. Assumes a 40 MHz APB clock and 32-bit APB data.
*/
`default_nettype none
package iosj_pkg;
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int JUMP_LOW_W = 11;
  localparam int CLK_PERIOD_NS = 25;

  // Register byte offsets
  localparam logic [11:0] OFF_ISSUE = 12'h000;
  localparam logic [11:0] OFF_WREG = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_LATCH = 12'h00C;
  localparam logic [11:0] OFF_PC = 12'h010;
  localparam logic [11:0] OFF_CYCLES = 12'h014;
  localparam logic [2:0] MEM_WINDOW_TAG = 3'h1;

  // Issue word fields
  localparam int ISSUE_OP_LSB = 0;
  localparam int ISSUE_D_POS = 3;
  localparam int ISSUE_F_LSB = 4;
  localparam int ISSUE_K_LSB = 16;

  // Status fields
  localparam int STAT_C_POS = 0;
  localparam int STAT_Z_POS = 1;

  // Jump latch slice feeding the upper program counter
  localparam int LATCH_JUMP_LSB = 3;

  // Reset values
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic C_RST = 1'b0;
  localparam logic Z_RST = 1'b0;
  localparam logic [6:0] LATCH_RST = 7'h00;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [31:0] CYCLES_RST = 32'h0000_0000;

  // Destination select and program counter steps
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;
  localparam logic [14:0] PC_STEP = 15'h0001;
  localparam logic [14:0] PC_SKIP_STEP = 15'h0002;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_INC_SKIP = 3'b001,
    OP_JUMP = 3'b010,
    OP_OR_LIT = 3'b011,
    OP_INC = 3'b100,
    OP_OR_FILE = 3'b101,
    OP_SHL = 3'b110
  } iosj_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SECOND = 2'b10,
    ST_DONE = 2'b11
  } iosj_state_type;

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction
endpackage
`default_nettype wire

// File: hw/iosj_alu.sv
/*
 Combinational result and flag logic for one instruction.
 Assumes the caller routes the result and commits flags itself.
*/
`timescale 1ns/1ps
`default_nettype none
module iosj_alu import iosj_pkg::*; (
  // Instruction
  input wire iosj_op_type op,
  input wire logic [7:0] lit,
  // Operands
  input wire logic [7:0] w_val,
  input wire logic [7:0] f_val,
  input wire logic c_in,
  // Results
  output logic [7:0] res,
  output logic c_out,
  output logic upd_c,
  output logic upd_z,
  output logic res_zero
);
  always_comb begin
    res = f_val;
    c_out = c_in;
    upd_c = 1'b0;
    upd_z = 1'b0;
    unique case (op)
      OP_INC_SKIP: begin
        res = f_val + 8'h01; // RQ1
      end
      OP_INC: begin
        res = f_val + 8'h01; // RQ8
        upd_z = 1'b1;
      end
      OP_OR_LIT: begin
        res = w_val | lit; // RQ7
        upd_z = 1'b1;
      end
      OP_OR_FILE: begin
        res = w_val | f_val; // RQ9
        upd_z = 1'b1;
      end
      OP_SHL: begin
        res = {f_val[6:0], 1'b0}; // RQ10
        c_out = f_val[7]; // RQ10
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      OP_JUMP, OP_NOP: begin
        res = f_val;
      end
      default: begin
        res = f_val;
      end
    endcase
  end

  assign res_zero = is_zero(res); // RQ11
endmodule
`default_nettype wire

// File: hw/iosj_exec.sv
/*
 Execution block for increment-with-skip, increment, OR with literal,
 OR with file, left shift and absolute jump, behind an APB slave.
 Assumes an APB master on pclk; one instruction per write to the
 issue word, whose access phase waits until execution has finished.
*/
// Contract
// RQ1: Skip increment adds one, flags untouched
// RQ2: Zero sum replaces next with no-op
// RQ3: Select zero to accumulator, one to file
// RQ4: Jump literal loads counter bits ten..zero
// RQ5: Latch bits six..three fill upper counter
// RQ6: Jump takes two cycles, flags untouched
// RQ7: OR literal into accumulator, zero updated
// RQ8: Plain increment updates zero, no skip
// RQ9: OR accumulator with file, zero updated
// RQ10: Left shift, top bit to carry
// RQ11: Zero flag set when result is zero
`timescale 1ns/1ps
`default_nettype none
module iosj_exec import iosj_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state view
  output logic [14:0] pc,
  output logic busy
);
  iosj_state_type state_r;
  iosj_op_type op_r;
  logic d_r;
  logic [6:0] f_r;
  logic [10:0] k_r;
  logic [7:0] w_r;
  logic c_r;
  logic z_r;
  logic [6:0] latch_r;
  logic [14:0] pc_r;
  logic [31:0] cycles_r;
  logic [31:0] prdata_r;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] f_val;
  logic [7:0] alu_res;
  logic alu_c;
  logic upd_c;
  logic upd_z;
  logic res_zero;
  logic in_exec;
  logic to_file;
  logic to_w;
  logic two_cycle;
  logic is_mem;
  logic is_issue;
  logic known;
  logic access;
  logic apb_wr;
  logic issue_go;
  logic [6:0] mem_idx;

  function automatic logic reg_known(input logic [11:0] a);
    return a == OFF_ISSUE || a == OFF_WREG || a == OFF_STAT ||
           a == OFF_LATCH || a == OFF_PC || a == OFF_CYCLES ||
           a[11:9] == MEM_WINDOW_TAG;
  endfunction

  // Address decode
  assign is_mem = paddr[11:9] == MEM_WINDOW_TAG;
  assign is_issue = paddr == OFF_ISSUE;
  assign known = reg_known(paddr);
  assign mem_idx = paddr[8:2];
  assign access = psel && penable;

  // Issue writes stall until the instruction has run
  assign pready = !(pwrite && is_issue) || state_r == ST_DONE;
  assign pslverr = access && pready && !known;
  assign apb_wr = access && pwrite && pready && known && !is_issue;
  assign issue_go = access && pwrite && is_issue && state_r == ST_IDLE;
  assign prdata = prdata_r;
  assign pc = pc_r;
  assign busy = state_r != ST_IDLE;

  assign f_val = file_mem[f_r];
  assign in_exec = state_r == ST_EXEC;

  iosj_alu u_alu (
    .op(op_r),
    .lit(k_r[7:0]),
    .w_val(w_r),
    .f_val(f_val),
    .c_in(c_r),
    .res(alu_res),
    .c_out(alu_c),
    .upd_c(upd_c),
    .upd_z(upd_z),
    .res_zero(res_zero)
  );

  // Result routing
  always_comb begin
    to_file = 1'b0;
    to_w = 1'b0;
    two_cycle = 1'b0;
    unique case (op_r)
      OP_INC_SKIP: begin
        to_file = d_r == DEST_F; // RQ3
        to_w = d_r == DEST_W; // RQ3
        two_cycle = res_zero; // RQ2
      end
      OP_INC, OP_OR_FILE, OP_SHL: begin
        to_file = d_r == DEST_F; // RQ3
        to_w = d_r == DEST_W; // RQ3
      end
      OP_OR_LIT: begin
        to_w = 1'b1; // RQ7
      end
      OP_JUMP: begin
        two_cycle = 1'b1; // RQ6
      end
      OP_NOP: begin
        two_cycle = 1'b0;
      end
      default: begin
        two_cycle = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (issue_go) state_r <= ST_EXEC;
        ST_EXEC: state_r <= two_cycle ? ST_SECOND : ST_DONE; // RQ2 RQ6
        ST_SECOND: state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
      endcase
    end
  end

  // Instruction capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= OP_NOP;
      d_r <= DEST_W;
      f_r <= 7'h00;
      k_r <= 11'h000;
    end else if (issue_go) begin
      op_r <= iosj_op_type'(pwdata[ISSUE_OP_LSB +: 3]);
      d_r <= pwdata[ISSUE_D_POS];
      f_r <= pwdata[ISSUE_F_LSB +: 7];
      k_r <= pwdata[ISSUE_K_LSB +: JUMP_LOW_W];
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r <= W_RST;
    end else if (in_exec && to_w) begin
      w_r <= alu_res; // RQ3 RQ7
    end else if (apb_wr && paddr == OFF_WREG) begin
      w_r <= pwdata[7:0];
    end
  end

  // Data file
  always_ff @(posedge pclk) begin
    if (in_exec && to_file) begin
      file_mem[f_r] <= alu_res; // RQ3
    end else if (apb_wr && is_mem) begin
      file_mem[mem_idx] <= pwdata[7:0];
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_r <= C_RST;
      z_r <= Z_RST;
    end else if (in_exec) begin
      if (upd_c) c_r <= alu_c; // RQ10
      if (upd_z) z_r <= res_zero; // RQ11
    end else if (apb_wr && paddr == OFF_STAT) begin
      c_r <= pwdata[STAT_C_POS];
      z_r <= pwdata[STAT_Z_POS];
    end
  end

  // Upper jump latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_r <= LATCH_RST;
    end else if (apb_wr && paddr == OFF_LATCH) begin
      latch_r <= pwdata[6:0];
    end
  end

  // Program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= PC_RST;
    end else if (in_exec) begin
      if (op_r == OP_JUMP) begin
        pc_r <= {latch_r[LATCH_JUMP_LSB +: 4], k_r}; // RQ4 RQ5
      end else if (op_r == OP_INC_SKIP && res_zero) begin
        pc_r <= pc_r + PC_SKIP_STEP; // RQ2
      end else begin
        pc_r <= pc_r + PC_STEP;
      end
    end else if (apb_wr && paddr == OFF_PC) begin
      pc_r <= pwdata[14:0];
    end
  end

  // Instruction cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles_r <= CYCLES_RST;
    end else if (in_exec || state_r == ST_SECOND) begin
      cycles_r <= cycles_r + 32'h0000_0001;
    end
  end

  // Read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (is_mem) begin
        prdata_r[7:0] <= file_mem[mem_idx];
      end else begin
        unique case (paddr)
          OFF_ISSUE: prdata_r <= {16'h0000, 14'h0000, busy, 1'b0};
          OFF_WREG: prdata_r[7:0] <= w_r;
          OFF_STAT: prdata_r[1:0] <= {z_r, c_r};
          OFF_LATCH: prdata_r[6:0] <= latch_r;
          OFF_PC: prdata_r[14:0] <= pc_r;
          OFF_CYCLES: prdata_r <= cycles_r;
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_one_cycle;
    state_r == ST_DONE;
  endsequence

  sequence s_two_cycle;
    state_r == ST_SECOND ##1 state_r == ST_DONE;
  endsequence

  chk_skip_flags_kept: assert property ( // RQ1
    in_exec && op_r == OP_INC_SKIP |=> $stable(c_r) && $stable(z_r))
    else $error("skip increment changed a flag");

  chk_skip_two_cycle: assert property ( // RQ2
    in_exec && op_r == OP_INC_SKIP && f_val == 8'hFF
    |=> pc_r == $past(pc_r) + PC_SKIP_STEP ##0 s_two_cycle)
    else $error("zero skip did not take two cycles");

  chk_noskip_one_cycle: assert property ( // RQ2
    in_exec && op_r == OP_INC_SKIP && f_val != 8'hFF
    |=> pc_r == $past(pc_r) + PC_STEP ##0 s_one_cycle)
    else $error("nonzero skip increment skipped");

  chk_dest_select_w: assert property ( // RQ3
    in_exec && op_r inside {OP_INC_SKIP, OP_INC, OP_OR_FILE, OP_SHL}
    && d_r == DEST_W |=> w_r == $past(alu_res))
    else $error("select zero did not reach accumulator");

  chk_dest_select_f: assert property ( // RQ3
    in_exec && op_r == OP_INC && d_r == DEST_F
    |=> w_r == $past(w_r) && file_mem[f_r] == $past(f_val) + 8'h01)
    else $error("select one did not reach file");

  chk_jump_low_bits: assert property ( // RQ4
    in_exec && op_r == OP_JUMP |=> pc_r[10:0] == $past(k_r))
    else $error("jump low bits wrong");

  chk_jump_high_bits: assert property ( // RQ5
    in_exec && op_r == OP_JUMP |=> pc_r[14:11] == $past(latch_r[6:3]))
    else $error("jump high bits wrong");

  chk_jump_two_cycle: assert property ( // RQ6
    in_exec && op_r == OP_JUMP
    |=> $stable(c_r) && $stable(z_r) ##0 s_two_cycle)
    else $error("jump timing or flags wrong");

  chk_or_literal: assert property ( // RQ7
    in_exec && op_r == OP_OR_LIT
    |=> w_r == ($past(w_r) | $past(k_r[7:0])) && z_r == is_zero(w_r))
    else $error("literal OR result wrong");

  chk_inc_plain: assert property ( // RQ8
    in_exec && op_r == OP_INC && d_r == DEST_W
    |=> w_r == $past(f_val) + 8'h01 && z_r == is_zero(w_r) ##0 s_one_cycle)
    else $error("increment result or zero wrong");

  chk_or_file: assert property ( // RQ9
    in_exec && op_r == OP_OR_FILE && d_r == DEST_W
    |=> w_r == ($past(w_r) | $past(f_val)))
    else $error("file OR result wrong");

  chk_shift_carry: assert property ( // RQ10
    in_exec && op_r == OP_SHL
    |=> c_r == $past(f_val[7]) && $past(alu_res) == {$past(f_val[6:0]), 1'b0})
    else $error("left shift wrong");

  chk_zero_flag: assert property ( // RQ11
    in_exec && upd_z |=> z_r == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");

  chk_skip_dest_file: assert property ( // RQ1
    in_exec && op_r == OP_INC_SKIP && d_r == DEST_F
    |=> file_mem[f_r] == $past(f_val) + 8'h01 && w_r == $past(w_r))
    else $error("skip increment did not reach file");

  chk_inc_no_skip: assert property ( // RQ8
    in_exec && op_r == OP_INC
    |=> pc_r == $past(pc_r) + PC_STEP ##0 s_one_cycle)
    else $error("plain increment skipped");

  chk_or_file_dest: assert property ( // RQ9
    in_exec && op_r == OP_OR_FILE && d_r == DEST_F
    |=> file_mem[f_r] == ($past(w_r) | $past(f_val)) && w_r == $past(w_r))
    else $error("file OR did not reach file");

  chk_or_lit_file_kept: assert property ( // RQ7
    in_exec && op_r == OP_OR_LIT
    |=> file_mem[f_r] == $past(f_val) && $stable(c_r))
    else $error("literal OR touched file or carry");

  chk_shift_dest: assert property ( // RQ10
    in_exec && op_r == OP_SHL
    |=> (d_r == DEST_W ? w_r : file_mem[f_r]) == {$past(f_val[6:0]), 1'b0})
    else $error("left shift result not stored");

  chk_jump_no_write: assert property ( // RQ6
    in_exec && op_r == OP_JUMP
    |=> w_r == $past(w_r) && file_mem[f_r] == $past(f_val))
    else $error("jump wrote a register");
endmodule
`default_nettype wire

// File: sim/iosj_ref.sv
/*
 Behavioural model of the core state that the execution block works on.
 Assumes the bench mirrors every register write into it.
*/
`timescale 1ns/1ps
`default_nettype none
module iosj_ref;
  logic [7:0] w = 8'h00;
  logic [7:0] file [128];
  logic c = 1'b0;
  logic z = 1'b0;
  logic [6:0] latch = 7'h00;
  logic [14:0] pc = 15'h0000;
  logic [31:0] cyc = 32'h0000_0000;

  // Applies one instruction, returns expected wait states
  task automatic run(input logic [2:0] op, input logic d,
    input logic [6:0] f, input logic [10:0] k, output int wt);
    logic [7:0] r;
    logic two;
    logic dst;
    two = 1'b0;
    dst = op == 3'h1 || (op >= 3'h4 && op <= 3'h6);
    r = file[f];
    case (op)
      3'h1: begin
        r = file[f] + 8'h01;
        two = r == 8'h00;
      end
      3'h2: begin
        pc = {latch[6:3], k};
        two = 1'b1;
      end
      3'h3: r = w | k[7:0];
      3'h4: r = file[f] + 8'h01;
      3'h5: r = w | file[f];
      3'h6: begin
        c = file[f][7];
        r = {file[f][6:0], 1'b0};
      end
      default: ;
    endcase
    if (op >= 3'h3 && op <= 3'h6) z = r == 8'h00;
    if (op == 3'h3 || (dst && d == 1'b0)) w = r;
    else if (dst) file[f] = r;
    if (op != 3'h2) pc = pc + (two ? 15'h0002 : 15'h0001);
    cyc = cyc + (two ? 32'h2 : 32'h1);
    wt = two ? 3 : 2;
  endtask
endmodule
`default_nettype wire

// File: sim/iosj_exec_tb_top.sv
/*
 Self-checking bench for the execution block over APB.
 Assumes the reference model tracks all state the bench writes.
*/
`timescale 1ns/1ps
`default_nettype none
module iosj_exec_tb_top import iosj_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, busy;
  logic [14:0] pc;
  int mismatches = 0;
  int tests_run = 0;
  int wcnt = 0;
  logic [32:0] rq [$];
  int wq [$];
  logic [15:0] pq [$];

  always #12.5 pclk = ~pclk;

  iosj_exec iosj_exec_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc(pc),
    .busy(busy));
  iosj_ref iosj_ref_inst();

  task wrap_up;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task cmp_read(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp_core(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp_wait(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Watcher: checks each finished read and issue write against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready !== 1'b1)
      wcnt <= wcnt + 1;
    if (psel && penable && pready === 1'b1) begin
      wcnt <= 0;
      if (!pwrite && rq.size() > 0)
        cmp_read({pslverr, prdata}, rq.pop_front());
      else if (pwrite && paddr == OFF_ISSUE && wq.size() > 0) begin
        cmp_wait(wcnt, wq.pop_front());
        cmp_core({busy, pc}, pq.pop_front());
      end
    end
  end

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask

  task rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task put(input logic [6:0] f, input logic [7:0] fv, input logic [7:0] wv,
    input logic [1:0] sv, input logic [6:0] lv);
    apb(1'b1, 12'h200 + {3'h0, f, 2'h0}, {24'h000000, fv});
    apb(1'b1, OFF_WREG, {24'h000000, wv});
    apb(1'b1, OFF_STAT, {30'h00000000, sv});
    apb(1'b1, OFF_LATCH, {25'h0000000, lv});
    iosj_ref_inst.file[f] = fv;
    iosj_ref_inst.w = wv;
    iosj_ref_inst.c = sv[0];
    iosj_ref_inst.z = sv[1];
    iosj_ref_inst.latch = lv;
  endtask

  task issue(input logic [2:0] op, input logic d, input logic [6:0] f,
    input logic [10:0] k);
    int wt;
    iosj_ref_inst.run(op, d, f, k, wt);
    wq.push_back(wt);
    pq.push_back({1'b1, iosj_ref_inst.pc});
    apb(1'b1, OFF_ISSUE, {5'h00, k, 5'h00, f, d, op});
  endtask

  task chk(input logic [6:0] f);
    rd(OFF_WREG, {25'h0000000, iosj_ref_inst.w});
    rd(OFF_STAT, {31'h0, iosj_ref_inst.z, iosj_ref_inst.c});
    rd(OFF_PC, {18'h00000, iosj_ref_inst.pc});
    rd(12'h200 + {3'h0, f, 2'h0}, {25'h0, iosj_ref_inst.file[f]});
    rd(OFF_CYCLES, {1'b0, iosj_ref_inst.cyc});
    rd(OFF_ISSUE, 33'h0);
  endtask

  initial begin
    logic [2:0] op;
    logic [7:0] fv;
    logic [7:0] wv;
    logic [6:0] f;
    logic [10:0] k;
    void'($urandom(32'ha9db520b));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Data file has no reset value
    apb(1'b1, 12'h200, 32'h0000_0000);
    iosj_ref_inst.file[0] = 8'h00;
    chk(7'h00);
    rd(OFF_LATCH, 33'h0);
    rd(12'h100, {1'b1, 32'h0000_0000});
    for (int i = 0; i < 24; i++) begin
      op = 3'(1 + i % 6);
      f = i >= 12 ? 7'h7F : 7'($urandom);
      fv = 8'($urandom);
      wv = 8'($urandom);
      k = 11'($urandom);
      // Second pass forces zero results, skips and carry out
      if (i >= 12) begin
        fv = op == 3'h5 ? 8'h00 : (op == 3'h6 ? 8'h80 : 8'hFF);
        wv = 8'h00;
        k[7:0] = 8'h00;
      end
      put(f, fv, wv, 2'($urandom), 7'($urandom));
      issue(op, 1'(i / 6), f, k);
      chk(f);
    end
    // Opcodes with no operation still step the counter
    for (int j = 0; j < 2; j++) begin
      put(7'h05, 8'($urandom), 8'($urandom), 2'($urandom), 7'($urandom));
      issue(3'(7 * j), 1'(j), 7'h05, 11'($urandom));
      chk(7'h05);
    end
    repeat (3) @(posedge pclk);
    // Every noted result must have been seen
    if (rq.size() != 0 || wq.size() != 0 || pq.size() != 0)
      mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
